// [ufc_defines.svh]
// Register offsets, field positions, reset values and timing counts of the UART
`ifndef UFC_DEFINES_SVH
`define UFC_DEFINES_SVH
`define UFC_CLK_HZ 100000000
`define UFC_FIFO_DEPTH 16
`define UFC_PTR_W 4
`define UFC_CNT_W 5
`define UFC_RTS_LEVEL 5'h0f
`define UFC_OVERSAMPLE 16
`define UFC_OFF_DATA 6'h00
`define UFC_OFF_IER 6'h04
`define UFC_OFF_FCR 6'h08
`define UFC_OFF_LCR 6'h0c
`define UFC_OFF_MCR 6'h10
`define UFC_OFF_LSR 6'h14
`define UFC_OFF_MSR 6'h18
`define UFC_OFF_DIV 6'h1c
`define UFC_OFF_LVL 6'h20
`define UFC_IER_RX 0
`define UFC_IER_TX 1
`define UFC_IER_LS 2
`define UFC_IER_MS 3
`define UFC_FCR_RXCLR 1
`define UFC_FCR_TXCLR 2
`define UFC_FCR_TRIG 6
`define UFC_LCR_LEN 0
`define UFC_LCR_STOP 2
`define UFC_LCR_PEN 3
`define UFC_LCR_EVEN 4
`define UFC_LCR_STICK 5
`define UFC_MCR_RTS 0
`define UFC_MCR_LOOP 1
`define UFC_MCR_AUTO 2
`define UFC_MCR_PINS 3
`define UFC_LVL_RX 8
`define UFC_LCR_RESET 8'h03
`define UFC_MCR_RESET 4'h8
`define UFC_IER_RESET 4'h0
`define UFC_DIV_RESET 16'h028a
`define UFC_IIR_LS 4'h6
`define UFC_IIR_RX 4'h4
`define UFC_IIR_TO 4'hc
`define UFC_IIR_TX 4'h2
`define UFC_IIR_MS 4'h0
`define UFC_IIR_NONE 4'h1
`endif

// [ufc_pkg.sv]
// Types shared by the UART: bus carriers, state enums and the state record
`include "ufc_defines.svh"
package ufc_pkg;
	typedef enum logic [2:0] {UFC_TX_IDLE, UFC_TX_START, UFC_TX_DATA, UFC_TX_PAR, UFC_TX_STOP} ufc_tx_st_t;
	typedef enum logic [2:0] {UFC_RX_IDLE, UFC_RX_START, UFC_RX_DATA, UFC_RX_PAR, UFC_RX_STOP} ufc_rx_st_t;
	typedef struct packed {
		logic read;
		logic write;
		logic [5:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} ufc_avs_req_t;
	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} ufc_avs_rsp_t;
	typedef struct packed {
		logic [`UFC_FIFO_DEPTH-1:0][7:0] txq;
		logic [`UFC_PTR_W-1:0] txw;
		logic [`UFC_PTR_W-1:0] txr;
		logic [`UFC_CNT_W-1:0] txc;
		logic [`UFC_FIFO_DEPTH-1:0][10:0] rxq;
		logic [`UFC_PTR_W-1:0] rxw;
		logic [`UFC_PTR_W-1:0] rxr;
		logic [`UFC_CNT_W-1:0] rxc;
		logic [3:0] ier;
		logic [7:0] lcr;
		logic [3:0] mcr;
		logic [1:0] trig;
		logic [15:0] div;
		logic [15:0] baud_cnt;
		ufc_tx_st_t tx_st;
		logic [4:0] tx_tick;
		logic [2:0] tx_bit;
		logic [7:0] tx_sh;
		ufc_rx_st_t rx_st;
		logic [3:0] rx_tick;
		logic [2:0] rx_bit;
		logic [7:0] rx_sh;
		logic rx_perr;
		logic rx_pbit;
		logic rx_prev;
		logic overrun;
		logic brk_seen;
		logic thre_flag;
		logic to_flag;
		logic [15:0] to_cnt;
		logic dcts;
		logic cts_prev;
		logic rts_off;
		logic txd;
		logic txd_pin;
		logic rts_n;
		logic flow_en;
		logic irq;
		ufc_avs_rsp_t rsp;
	} ufc_state_t;
endpackage : ufc_pkg

// [ufc_uart.sv]
// UART with 16-byte queues, programmable framing, flow control and an Avalon-MM slave
`timescale 1ns/1ps
`include "ufc_defines.svh"
module ufc_uart (
	input wire logic core_clk_i, // System clock, 100 MHz
	input wire logic rst_i, // Asynchronous reset, active high
	input wire ufc_pkg::ufc_avs_req_t avs_req_i, // Avalon-MM request
	output ufc_pkg::ufc_avs_rsp_t avs_rsp_o, // Avalon-MM read data and waitrequest
	input wire logic rxd_i, // Serial receive line
	output logic txd_o, // Serial transmit line
	input wire logic cts_n_i, // Clear to send, active low
	output logic rts_n_o, // Request to send, active low
	output logic flow_pins_en_o, // High while CTS/RTS own their pins
	output logic irq_o // Interrupt request, active high
);
	import ufc_pkg::*;

	ufc_state_t s_reg;
	ufc_state_t s_next;

	// Trigger level selected by the two trigger bits
	function automatic logic [4:0] trig_level(input logic [1:0] t);
		case (t)
			2'h0: trig_level = 5'h01;
			2'h1: trig_level = 5'h04;
			2'h2: trig_level = 5'h08;
			default: trig_level = 5'h0e;
		endcase
	endfunction : trig_level

	// Parity bit for a character; stick mode forces a constant
	function automatic logic par_bit(input logic [7:0] d, input logic [7:0] lcr);
		logic [7:0] m;
		m = d & (8'hff >> (2'h3 - lcr[`UFC_LCR_LEN +: 2]));
		if (lcr[`UFC_LCR_STICK])
			par_bit = ~lcr[`UFC_LCR_EVEN];
		else
			par_bit = lcr[`UFC_LCR_EVEN] ? ^m : ~^m;
	endfunction : par_bit

	// Oversample ticks spent in the stop period, less one
	function automatic logic [4:0] stop_ticks(input logic [7:0] lcr);
		if (!lcr[`UFC_LCR_STOP])
			stop_ticks = 5'h0f;
		else if (lcr[`UFC_LCR_LEN +: 2] == 2'h0)
			stop_ticks = 5'h17;
		else
			stop_ticks = 5'h1f;
	endfunction : stop_ticks

	// Four character times in oversample ticks, for the receive timeout
	function automatic logic [15:0] four_chars(input logic [7:0] lcr);
		logic [15:0] bits;
		bits = 16'h0007 + {14'h0, lcr[`UFC_LCR_LEN +: 2]} + {15'h0, lcr[`UFC_LCR_PEN]}
			+ {15'h0, lcr[`UFC_LCR_STOP]};
		four_chars = bits << 6;
	endfunction : four_chars

	// Next state of the whole block
	always_comb
	begin
		logic tick, rx_in, cts_ok, take, ls_pend;
		logic tx_push, tx_pop, rx_push, rx_pop, tx_clr, rx_clr;
		logic [10:0] rx_word, head;
		logic [3:0] iir;
		logic [5:0] addr;
		logic [31:0] wd;
		s_next = s_reg;
		tick = (s_reg.baud_cnt >= s_reg.div);
		rx_in = s_reg.mcr[`UFC_MCR_LOOP] ? s_reg.txd : rxd_i;
		cts_ok = !cts_n_i || !s_reg.mcr[`UFC_MCR_PINS];
		tx_push = 1'b0;
		tx_pop = 1'b0;
		rx_push = 1'b0;
		rx_pop = 1'b0;
		tx_clr = 1'b0;
		rx_clr = 1'b0;
		rx_word = {s_reg.rx_sh == 8'h00 && !rx_in && !s_reg.rx_pbit, !rx_in, s_reg.rx_perr,
			s_reg.rx_sh};
		head = s_reg.rxq[s_reg.rxr];
		addr = {avs_req_i.address[5:2], 2'b00};
		wd = avs_req_i.writedata;

		// Pending interrupt, highest priority first
		ls_pend = s_reg.overrun || s_reg.brk_seen || (s_reg.rxc != 5'h00 && (head[9] || head[8]));
		if (s_reg.ier[`UFC_IER_LS] && ls_pend)
			iir = `UFC_IIR_LS;
		else if (s_reg.ier[`UFC_IER_RX] && s_reg.rxc >= trig_level(s_reg.trig))
			iir = `UFC_IIR_RX;
		else if (s_reg.ier[`UFC_IER_RX] && s_reg.to_flag)
			iir = `UFC_IIR_TO;
		else if (s_reg.ier[`UFC_IER_TX] && s_reg.thre_flag)
			iir = `UFC_IIR_TX;
		else if (s_reg.ier[`UFC_IER_MS] && s_reg.dcts)
			iir = `UFC_IIR_MS;
		else
			iir = `UFC_IIR_NONE;

		// Baud divider: one tick every div+1 clocks; >= lets a lowered divisor act at once
		s_next.baud_cnt = tick ? 16'h0000 : s_reg.baud_cnt + 16'h0001;

		// Bus slave: take a request once, answer one cycle later
		take = (avs_req_i.read || avs_req_i.write) && s_reg.rsp.waitrequest;
		s_next.rsp.waitrequest = !take;
		if (take && avs_req_i.read)
		begin
			case (addr)
				`UFC_OFF_DATA:
				begin
					s_next.rsp.readdata = {24'h0, head[7:0]};
					rx_pop = (s_reg.rxc != 5'h00);
				end
				`UFC_OFF_IER: s_next.rsp.readdata = {28'h0, s_reg.ier};
				`UFC_OFF_FCR:
				begin
					s_next.rsp.readdata = {24'h0, s_reg.trig, 2'b00, iir};
					if (iir == `UFC_IIR_TX)
						s_next.thre_flag = 1'b0;
				end
				`UFC_OFF_LCR: s_next.rsp.readdata = {24'h0, s_reg.lcr};
				`UFC_OFF_MCR: s_next.rsp.readdata = {28'h0, s_reg.mcr};
				`UFC_OFF_LSR:
				begin
					// Overrun and break are sticky until this read
					s_next.rsp.readdata = {24'h0, s_reg.tx_st != UFC_TX_IDLE,
						s_reg.txc == 5'h00 && s_reg.tx_st == UFC_TX_IDLE, s_reg.txc == 5'h00,
						s_reg.brk_seen, s_reg.rxc != 5'h00 && head[9],
						s_reg.rxc != 5'h00 && head[8], s_reg.overrun, s_reg.rxc != 5'h00};
					s_next.overrun = 1'b0;
					s_next.brk_seen = 1'b0;
				end
				`UFC_OFF_MSR:
				begin
					s_next.rsp.readdata = {27'h0, !cts_n_i, 3'h0, s_reg.dcts};
					s_next.dcts = 1'b0;
				end
				`UFC_OFF_DIV: s_next.rsp.readdata = {16'h0, s_reg.div};
				`UFC_OFF_LVL: s_next.rsp.readdata = {19'h0, s_reg.rxc, 3'h0, s_reg.txc};
				default: s_next.rsp.readdata = 32'h0000_0000;
			endcase
		end
		if (take && avs_req_i.write && avs_req_i.byteenable[0])
		begin
			case (addr)
				`UFC_OFF_DATA:
				begin
					tx_push = (s_reg.txc != 5'h10);
					s_next.thre_flag = 1'b0;
				end
				`UFC_OFF_IER: s_next.ier = wd[3:0];
				`UFC_OFF_FCR:
				begin
					rx_clr = wd[`UFC_FCR_RXCLR];
					tx_clr = wd[`UFC_FCR_TXCLR];
					s_next.trig = wd[`UFC_FCR_TRIG +: 2];
				end
				`UFC_OFF_LCR: s_next.lcr = {2'b00, wd[5:0]};
				`UFC_OFF_MCR: s_next.mcr = wd[3:0];
				`UFC_OFF_DIV: s_next.div[7:0] = wd[7:0];
				default: s_next.ier = s_reg.ier;
			endcase
		end
		if (take && avs_req_i.write && avs_req_i.byteenable[1] && addr == `UFC_OFF_DIV)
			s_next.div[15:8] = wd[15:8];

		// Transmitter
		if (s_reg.tx_st == UFC_TX_IDLE)
		begin
			s_next.tx_tick = 5'h00;
			// With the flow pins enabled, auto mode holds a queued character until CTS is asserted
			if (tick && s_reg.txc != 5'h00 && (!s_reg.mcr[`UFC_MCR_AUTO] || cts_ok))
			begin
				tx_pop = 1'b1;
				s_next.tx_sh = s_reg.txq[s_reg.txr];
				s_next.tx_bit = 3'h0;
				s_next.txd = 1'b0;
				s_next.tx_st = UFC_TX_START;
				if (s_reg.txc == 5'h01)
					s_next.thre_flag = 1'b1;
			end
		end
		else if (tick)
		begin
			s_next.tx_tick = s_reg.tx_tick + 5'h01;
			case (s_reg.tx_st)
				UFC_TX_START:
					if (s_reg.tx_tick == 5'h0f)
					begin
						s_next.tx_tick = 5'h00;
						s_next.txd = s_reg.tx_sh[0];
						s_next.tx_st = UFC_TX_DATA;
					end
				UFC_TX_DATA:
					if (s_reg.tx_tick == 5'h0f)
					begin
						s_next.tx_tick = 5'h00;
						s_next.tx_bit = s_reg.tx_bit + 3'h1;
						// Shifter stays whole so parity never reads a refilled queue slot
						s_next.txd = s_reg.tx_sh[s_reg.tx_bit + 3'h1];
						if (s_reg.tx_bit == {1'b1, s_reg.lcr[`UFC_LCR_LEN +: 2]})
						begin
							// Length reached: parity bit or stop
							s_next.tx_st = s_reg.lcr[`UFC_LCR_PEN] ? UFC_TX_PAR : UFC_TX_STOP;
							s_next.txd = s_reg.lcr[`UFC_LCR_PEN] ?
								par_bit(s_reg.tx_sh, s_reg.lcr) : 1'b1;
						end
					end
				UFC_TX_PAR:
					if (s_reg.tx_tick == 5'h0f)
					begin
						s_next.tx_tick = 5'h00;
						s_next.txd = 1'b1;
						s_next.tx_st = UFC_TX_STOP;
					end
				UFC_TX_STOP:
					if (s_reg.tx_tick == stop_ticks(s_reg.lcr))
						s_next.tx_st = UFC_TX_IDLE;
				default: s_next.tx_st = UFC_TX_IDLE;
			endcase
		end

		// Receiver, run on oversample ticks
		if (tick)
		begin
			s_next.rx_prev = rx_in;
			s_next.rx_tick = s_reg.rx_tick + 4'h1;
			case (s_reg.rx_st)
				UFC_RX_IDLE:
				begin
					s_next.rx_tick = 4'h0;
					if (s_reg.rx_prev && !rx_in)
						s_next.rx_st = UFC_RX_START;
				end
				UFC_RX_START:
					if (s_reg.rx_tick == 4'h7)
					begin
						s_next.rx_tick = 4'h0;
						s_next.rx_bit = 3'h0;
						s_next.rx_sh = 8'h00;
						s_next.rx_pbit = 1'b0;
						if (rx_in)
							s_next.rx_st = UFC_RX_IDLE;
						else
						begin
							s_next.rx_st = UFC_RX_DATA;
							if (s_reg.rxc == `UFC_RTS_LEVEL)
								s_next.rts_off = 1'b1;
						end
					end
				UFC_RX_DATA:
					if (s_reg.rx_tick == 4'hf)
					begin
						s_next.rx_sh[s_reg.rx_bit] = rx_in;
						s_next.rx_bit = s_reg.rx_bit + 3'h1;
						if (s_reg.rx_bit == {1'b1, s_reg.lcr[`UFC_LCR_LEN +: 2]})
							s_next.rx_st = s_reg.lcr[`UFC_LCR_PEN] ? UFC_RX_PAR : UFC_RX_STOP;
					end
				UFC_RX_PAR:
					if (s_reg.rx_tick == 4'hf)
					begin
						s_next.rx_pbit = rx_in;
						s_next.rx_perr = (rx_in != par_bit(s_reg.rx_sh, s_reg.lcr));
						s_next.rx_st = UFC_RX_STOP;
					end
				UFC_RX_STOP:
					if (s_reg.rx_tick == 4'hf)
					begin
						// Character complete: queue it or flag an overrun
						if (s_reg.rxc == 5'h10)
							s_next.overrun = 1'b1;
						else
							rx_push = 1'b1;
						if (rx_word[10])
							s_next.brk_seen = 1'b1;
						s_next.rx_perr = 1'b0;
						s_next.rx_st = UFC_RX_IDLE;
					end
				default: s_next.rx_st = UFC_RX_IDLE;
			endcase
		end
		if (!s_reg.lcr[`UFC_LCR_PEN])
			s_next.rx_perr = 1'b0;

		// Receive timeout: four idle character times while data waits
		if (rx_push || rx_pop || s_reg.rxc == 5'h00 || s_reg.rx_st != UFC_RX_IDLE)
			s_next.to_cnt = 16'h0000;
		else if (tick && s_reg.to_cnt != 16'hffff)
			s_next.to_cnt = s_reg.to_cnt + 16'h0001;
		s_next.to_flag = !(rx_push || rx_pop || rx_clr) &&
			(s_reg.to_flag || s_reg.to_cnt >= four_chars(s_reg.lcr));

		// Queue pointers and counts; a flush overrides traffic that cycle
		if (tx_push)
		begin
			s_next.txq[s_reg.txw] = wd[7:0];
			s_next.txw = s_reg.txw + 4'h1;
		end
		if (tx_pop)
			s_next.txr = s_reg.txr + 4'h1;
		s_next.txc = s_reg.txc + {4'h0, tx_push} - {4'h0, tx_pop};
		if (rx_push)
		begin
			s_next.rxq[s_reg.rxw] = rx_word;
			s_next.rxw = s_reg.rxw + 4'h1;
		end
		if (rx_pop)
		begin
			s_next.rxr = s_reg.rxr + 4'h1;
			s_next.rts_off = 1'b0;
		end
		s_next.rxc = s_reg.rxc + {4'h0, rx_push} - {4'h0, rx_pop};
		if (tx_clr)
		begin
			s_next.txw = 4'h0;
			s_next.txr = 4'h0;
			s_next.txc = 5'h00;
		end
		if (rx_clr)
		begin
			s_next.rxw = 4'h0;
			s_next.rxr = 4'h0;
			s_next.rxc = 5'h00;
			s_next.rts_off = 1'b0;
		end

		// CTS change detect; a change in the read cycle still sets the flag
		s_next.cts_prev = cts_n_i;
		if (cts_n_i != s_reg.cts_prev)
			s_next.dcts = 1'b1;

		// Pin drivers: disabled flow pins leave RTS inactive for the pin mux
		s_next.flow_en = s_reg.mcr[`UFC_MCR_PINS];
		if (!s_reg.mcr[`UFC_MCR_PINS])
			s_next.rts_n = 1'b1;
		else if (s_reg.mcr[`UFC_MCR_AUTO])
			s_next.rts_n = s_reg.rts_off;
		else
			s_next.rts_n = !s_reg.mcr[`UFC_MCR_RTS];
		s_next.irq = (iir != `UFC_IIR_NONE);
		s_next.txd_pin = s_next.txd | s_next.mcr[`UFC_MCR_LOOP];
	end

	// State register
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s_reg <= '0;
			s_reg.ier <= `UFC_IER_RESET;
			s_reg.lcr <= `UFC_LCR_RESET;
			s_reg.mcr <= `UFC_MCR_RESET;
			s_reg.div <= `UFC_DIV_RESET;
			s_reg.tx_st <= UFC_TX_IDLE;
			s_reg.rx_st <= UFC_RX_IDLE;
			s_reg.rx_prev <= 1'b1;
			s_reg.cts_prev <= 1'b1;
			s_reg.txd <= 1'b1;
			s_reg.txd_pin <= 1'b1;
			s_reg.rts_n <= 1'b1;
			s_reg.flow_en <= 1'b1;
			s_reg.rsp.waitrequest <= 1'b1;
		end
		else
			s_reg <= s_next;
	end

	// Outputs straight from the state register; loopback keeps the line idle
	assign avs_rsp_o = s_reg.rsp;
	assign txd_o = s_reg.txd_pin;
	assign rts_n_o = s_reg.rts_n;
	assign flow_pins_en_o = s_reg.flow_en;
	assign irq_o = s_reg.irq;
endmodule : ufc_uart

// [ufc_uart_sva.sv]
// Port-level assertions for the UART bus handshake and serial line
`timescale 1ns/1ps
module ufc_uart_sva (
	input wire logic core_clk_i, // System clock
	input wire logic rst_i, // Asynchronous reset
	input wire ufc_pkg::ufc_avs_req_t avs_req_i, // Bus request
	input wire ufc_pkg::ufc_avs_rsp_t avs_rsp_o, // Bus response
	input wire logic rxd_i, // Serial in
	input wire logic txd_o, // Serial out
	input wire logic cts_n_i, // Clear to send
	input wire logic rts_n_o, // Request to send
	input wire logic flow_pins_en_o, // Flow pins owned
	input wire logic irq_o // Interrupt
);
	import ufc_pkg::*;
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (rst_i);
	logic req;
	// Either strobe counts as a pending request
	assign req = avs_req_i.read | avs_req_i.write;
	// Answer exactly one cycle after the taking edge, lasting one cycle
	property p_ack;
		req && avs_rsp_o.waitrequest |=> !avs_rsp_o.waitrequest ##1 avs_rsp_o.waitrequest;
	endproperty
	a_ack: assert property (p_ack) else $error("bad ack timing");
	property p_no_ack;
		!avs_rsp_o.waitrequest |-> $past(req) && $past(avs_rsp_o.waitrequest);
	endproperty
	a_no_ack: assert property (p_no_ack) else $error("ack without request");
	// Read data only moves in the answer cycle of a read
	property p_rd_hold;
		$changed(avs_rsp_o.readdata) |-> !avs_rsp_o.waitrequest && $past(avs_req_i.read);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("readdata moved");
	property p_unmapped;
		avs_req_i.read && avs_rsp_o.waitrequest && avs_req_i.address[5:2] > 4'h8
			|=> avs_rsp_o.readdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	// No bit on the line is shorter than half a bit at the fastest divisor
	property p_low_bit;
		$fell(txd_o) |-> !txd_o [*8];
	endproperty
	a_low_bit: assert property (p_low_bit) else $error("short low bit");
	property p_high_bit;
		$rose(txd_o) |=> txd_o [*7];
	endproperty
	a_high_bit: assert property (p_high_bit) else $error("short high bit");
	property p_pins_off;
		!flow_pins_en_o && !$past(flow_pins_en_o) |-> rts_n_o;
	endproperty
	a_pins_off: assert property (p_pins_off) else $error("rts driven, pins off");
	property p_rst_out;
		$fell(rst_i) |-> txd_o && rts_n_o && flow_pins_en_o && !irq_o && avs_rsp_o.waitrequest;
	endproperty
	a_rst_out: assert property (p_rst_out) else $error("bad outputs after reset");
	c_read: cover property (avs_req_i.read && !avs_rsp_o.waitrequest);
	c_rts_off: cover property ($rose(rts_n_o));
	c_irq: cover property ($rose(irq_o));
	c_tx: cover property ($fell(txd_o));
endmodule : ufc_uart_sva
bind ufc_uart ufc_uart_sva u_sva (.core_clk_i(core_clk_i), .rst_i(rst_i),
	.avs_req_i(avs_req_i), .avs_rsp_o(avs_rsp_o), .rxd_i(rxd_i), .txd_o(txd_o),
	.cts_n_i(cts_n_i), .rts_n_o(rts_n_o), .flow_pins_en_o(flow_pins_en_o), .irq_o(irq_o));

// [ufc_remote.sv]
// Remote terminal model: decodes the UART output and sends frames to its input
`timescale 1ns/1ps
module ufc_remote (
	input wire logic clk_i, // System clock, 16 clocks a bit
	input wire logic line_i, // From the UART
	input wire logic rts_n_i, // UART ready, active low
	output logic line_o // To the UART
);
	logic [11:0] frm_q[$];
	time t_q[$];
	int nbits = 9;
	logic honour = 1'b1;
	initial line_o = 1'b1;
	// Decoder: start confirmed at mid bit, then one sample per bit centre
	always
	begin : dec
		logic [11:0] f;
		time t0;
		@(negedge line_i);
		t0 = $time;
		repeat (8) @(posedge clk_i);
		if (!line_i)
		begin
			f = 12'h0;
			for (int i = 0; i < nbits; i++)
			begin
				repeat (16) @(posedge clk_i);
				f[i] = line_i;
			end
			frm_q.push_back(f);
			t_q.push_back(t0);
		end
	end
	// Sender holds a character back while the UART withholds ready
	task automatic send(input logic [11:0] w, input int n);
		@(posedge clk_i);
		while (honour && rts_n_i)
			@(posedge clk_i);
		for (int i = -1; i <= n; i++)
		begin
			line_o <= (i < 0) ? 1'b0 : (i == n) ? 1'b1 : w[i];
			repeat (16) @(posedge clk_i);
		end
	endtask : send
	task automatic pulse(input int len);
		line_o <= 1'b0;
		repeat (len) @(posedge clk_i);
		line_o <= 1'b1;
	endtask : pulse
endmodule : ufc_remote

// [tb_top.sv]
// Self-checking bench: registers, framing, queues, flow control, interrupts
`timescale 1ns/1ps
`include "ufc_defines.svh"
module tb_top;
	import ufc_pkg::*;
	logic core_clk_i;
	logic rst_i;
	ufc_avs_req_t req;
	ufc_avs_rsp_t rsp;
	logic rxd;
	logic txd;
	logic cts_n;
	logic rts_n;
	logic pins_en;
	logic irq;
	int n_errors;
	int checks_done;
	logic [31:0] rv;
	logic [11:0] f;
	logic [2:0] pm [5] = '{3'b000, 3'b001, 3'b011, 3'b101, 3'b111};
	ufc_uart DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .avs_req_i(req), .avs_rsp_o(rsp),
		.rxd_i(rxd), .txd_o(txd), .cts_n_i(cts_n), .rts_n_o(rts_n),
		.flow_pins_en_o(pins_en), .irq_o(irq));
	ufc_remote u_rem (.clk_i(core_clk_i), .line_i(txd), .rts_n_i(rts_n), .line_o(rxd));
	// Clock and watchdog
	initial
	begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end
	initial
	begin
		#600000;
		n_errors++;
		end_sim();
	end
	task cyc(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask : cyc
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e)
		begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// Bus cycle: held until waitrequest is seen low at a rising edge
	task acc(input logic w, input logic [5:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge core_clk_i);
		req <= '{read: !w, write: w, address: a, writedata: d, byteenable: 4'hf};
		do
		begin
			@(posedge core_clk_i);
			t++;
		end
		while (rsp.waitrequest !== 1'b0 && t < 50);
		rv = rsp.readdata;
		req <= '0;
		if (t >= 50)
			chk(0, 1);
	endtask : acc
	task rdc(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
		acc(0, a, 0);
		chk(rv & m, e);
	endtask : rdc
	// Expected wire bits after the start bit: data, parity, first stop
	function automatic logic [11:0] frame(input logic [7:0] d, input logic [7:0] l);
		int n;
		logic [11:0] w;
		logic [7:0] m;
		n = l[1:0] + 5;
		m = 8'hff >> (3 - l[1:0]);
		w = {4'h0, d & m};
		w[n] = l[5] ? !l[4] : l[4] ? ^(d & m) : ~^(d & m);
		w[n + l[3]] = 1'b1;
		return w;
	endfunction : frame
	task getf;
		int t;
		t = 0;
		while (u_rem.frm_q.size() == 0 && t < 600)
		begin
			@(posedge core_clk_i);
			t++;
		end
		f = (t < 600) ? u_rem.frm_q.pop_front() : 12'hxxx;
	endtask : getf
	task t_reset;
		rdc(`UFC_OFF_IER, 32'hf, 32'h0);
		rdc(`UFC_OFF_LCR, 32'hff, 32'h03);
		rdc(`UFC_OFF_MCR, 32'hf, 32'h8);
		rdc(`UFC_OFF_DIV, 32'hffff, 32'h028a);
		rdc(`UFC_OFF_LSR, 32'hff, 32'h60);
		rdc(`UFC_OFF_FCR, 32'hf, 32'h1);
		rdc(`UFC_OFF_LVL, 32'h1f1f, 32'h0);
		rdc(6'h24, 32'hffffffff, 32'h0);
		chk({txd, rts_n, pins_en, irq}, 4'he);
		acc(1, `UFC_OFF_MCR, 32'h9);
		cyc(2);
		chk(rts_n, 1'b0);
		acc(1, `UFC_OFF_DIV, 32'h0);
		$display("t_reset done");
	endtask : t_reset
	// Every length with every parity mode, then stop spacing back to back
	task t_tx;
		logic [7:0] l;
		logic [7:0] d;
		int s;
		acc(1, `UFC_OFF_IER, 32'h2);
		for (int c = 0; c < 20; c++)
		begin
			l = {2'b00, pm[c % 5], c[0], 2'(c / 5)};
			d = 8'(53 + c * 37);
			acc(1, `UFC_OFF_LCR, {24'h0, l});
			u_rem.nbits = l[1:0] + 6 + l[3];
			acc(1, `UFC_OFF_DATA, {24'h0, d});
			if (c == 0)
			begin
				cyc(30);
				rdc(`UFC_OFF_LSR, 32'he0, 32'ha0);
				chk(irq, 1'b1);
				rdc(`UFC_OFF_FCR, 32'hf, 32'h2);
				cyc(2);
				chk(irq, 1'b0);
			end
			getf();
			chk(f, frame(d, l));
			cyc(40);
		end
		for (int i = 0; i < 2; i++)
		begin
			acc(1, `UFC_OFF_LCR, i ? 32'h07 : 32'h04);
			u_rem.nbits = i ? 9 : 6;
			acc(1, `UFC_OFF_DATA, 32'h0f);
			acc(1, `UFC_OFF_DATA, 32'hf0);
			getf();
			getf();
			s = int'((u_rem.t_q[$] - u_rem.t_q[$ - 1]) / 10);
			chk(s >= (i ? 176 : 120) && s <= (i ? 182 : 126), 1'b1);
			cyc(40);
		end
		acc(1, `UFC_OFF_IER, 32'h0);
		$display("t_tx done");
	endtask : t_tx
	task t_rx;
		logic [7:0] l;
		logic [7:0] d;
		for (int c = 0; c < 5; c++)
		begin
			l = {2'b00, pm[c], 1'b0, 2'(c % 4)};
			d = 8'hc6 ^ 8'(c * 17);
			acc(1, `UFC_OFF_LCR, {24'h0, l});
			u_rem.send(frame(d, l), l[1:0] + 6 + l[3]);
			rdc(`UFC_OFF_LSR, 32'h0f, 32'h01);
			rdc(`UFC_OFF_DATA, 32'hff, {24'h0, d & (8'hff >> (3 - l[1:0]))});
		end
		acc(1, `UFC_OFF_IER, 32'h4);
		acc(1, `UFC_OFF_LCR, 32'h1b);
		u_rem.send(frame(8'h5a, 8'h1b) ^ 12'h100, 10);
		rdc(`UFC_OFF_LSR, 32'h0f, 32'h05);
		chk(irq, 1'b1);
		rdc(`UFC_OFF_FCR, 32'hf, 32'h6);
		acc(0, `UFC_OFF_DATA, 0);
		u_rem.send(frame(8'h5a, 8'h1b) & 12'h1ff, 10);
		rdc(`UFC_OFF_LSR, 32'h0f, 32'h09);
		acc(0, `UFC_OFF_DATA, 0);
		u_rem.send(12'h0, 10);
		rdc(`UFC_OFF_LSR, 32'h11, 32'h11);
		acc(0, `UFC_OFF_DATA, 0);
		rdc(`UFC_OFF_LSR, 32'h11, 32'h00);
		u_rem.pulse(5);
		cyc(300);
		rdc(`UFC_OFF_LSR, 32'h01, 32'h00);
		acc(1, `UFC_OFF_IER, 32'h0);
		$display("t_rx done");
	endtask : t_rx
	// Auto flow: both queues full, overrun, flushes, modem change, timeout
	task t_flow;
		acc(1, `UFC_OFF_LCR, 32'h03);
		acc(1, `UFC_OFF_MCR, 32'hc);
		acc(1, `UFC_OFF_FCR, 32'hc0);
		acc(1, `UFC_OFF_IER, 32'h1);
		u_rem.nbits = 9;
		cts_n <= 1'b1;
		cyc(4);
		for (int i = 0; i < 17; i++)
			acc(1, `UFC_OFF_DATA, i);
		rdc(`UFC_OFF_LVL, 32'h1f, 32'h10);
		cyc(200);
		chk(u_rem.frm_q.size(), 0);
		for (int i = 0; i < 16; i++)
		begin
			u_rem.send(frame(8'(i), 8'h03), 9);
			if (i == 12)
				chk(irq, 1'b0);
			if (i == 13)
				chk(irq, 1'b1);
			if (i == 14)
				chk(rts_n, 1'b0);
		end
		chk(rts_n, 1'b1);
		rdc(`UFC_OFF_LVL, 32'h1f1f, 32'h1010);
		acc(1, `UFC_OFF_IER, 32'h5);
		u_rem.honour = 1'b0;
		u_rem.send(frame(8'h77, 8'h03), 9);
		u_rem.honour = 1'b1;
		chk(irq, 1'b1);
		rdc(`UFC_OFF_LSR, 32'h03, 32'h03);
		rdc(`UFC_OFF_DATA, 32'hff, 32'h00);
		cyc(3);
		chk(rts_n, 1'b0);
		acc(1, `UFC_OFF_FCR, 32'hc2);
		rdc(`UFC_OFF_LVL, 32'h1f1f, 32'h0010);
		acc(1, `UFC_OFF_IER, 32'h8);
		cts_n <= 1'b0;
		getf();
		chk(f, frame(8'h00, 8'h03));
		chk(irq, 1'b1);
		rdc(`UFC_OFF_FCR, 32'hf, 32'h0);
		rdc(`UFC_OFF_MSR, 32'h11, 32'h11);
		acc(1, `UFC_OFF_FCR, 32'hc4);
		rdc(`UFC_OFF_LVL, 32'h1f, 32'h0);
		cyc(250);
		u_rem.frm_q.delete();
		acc(1, `UFC_OFF_IER, 32'h1);
		u_rem.send(frame(8'h42, 8'h03), 9);
		cyc(200);
		chk(irq, 1'b0);
		cyc(600);
		rdc(`UFC_OFF_FCR, 32'hf, 32'hc);
		rdc(`UFC_OFF_DATA, 32'hff, 32'h42);
		acc(1, `UFC_OFF_IER, 32'h0);
		$display("t_flow done");
	endtask : t_flow
	// Loopback keeps the line idle; pins off frees transmit from the gate
	task t_misc;
		acc(1, `UFC_OFF_MCR, 32'hb);
		acc(1, `UFC_OFF_DATA, 32'ha5);
		cyc(250);
		chk(txd, 1'b1);
		rdc(`UFC_OFF_DATA, 32'hff, 32'ha5);
		chk(u_rem.frm_q.size(), 0);
		acc(1, `UFC_OFF_MCR, 32'h4);
		cts_n <= 1'b1;
		cyc(4);
		chk({pins_en, rts_n}, 2'b01);
		acc(1, `UFC_OFF_DATA, 32'h3c);
		getf();
		chk(f, frame(8'h3c, 8'h03));
		$display("t_misc done");
	endtask : t_misc
	task end_sim;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim
	// Reset for ten cycles, then the scenarios in turn
	initial
	begin
		rst_i = 1'b1;
		req = '0;
		cts_n = 1'b0;
		n_errors = 0;
		checks_done = 0;
		cyc(10);
		rst_i <= 1'b0;
		t_reset();
		t_tx();
		t_rx();
		t_flow();
		t_misc();
		end_sim();
	end
endmodule : tb_top
